// >>> eqcb_pkg.sv
// Constants, field layout and types for the equalizer control register bank
//
// How it works
// - Full-reset bit returns all registers and acquisition machine to reset state.
// - Acquisition-reset bit resets only the adaptation machine; registers keep contents.
// - Driver bits 7:6 select swing 400/600/700/800 mV; reset 10.
// - Driver bits 5:4 select offset 0.8/1.0/1.2 V or supply; reset 10.
// - Bit 3 enables de-emphasis, reset 0; bits 2:1 select level, reset 01.
// - Launch bit 7 selects 6 dB attenuated input; reset 0.
// - Driver-select bit 2 steers driver bits 7:1 to driver a or b.
package eqcb_pkg;

  localparam logic [7:0] EQCB_GEN_CTRL_OFS = 8'h00;
  localparam logic [7:0] EQCB_DRV_OFS = 8'h01;
  localparam logic [7:0] EQCB_LAUNCH_OFS = 8'h02;

  localparam int EQCB_GEN_ACQ_RST_BIT = 0;
  localparam int EQCB_GEN_FULL_RST_BIT = 1;
  localparam int EQCB_GEN_DRV_SEL_BIT = 2;
  localparam int EQCB_LAUNCH_BIT = 7;

  localparam int EQCB_CFG_SWING_MSB = 6;
  localparam int EQCB_CFG_SWING_LSB = 5;
  localparam int EQCB_CFG_CM_MSB = 4;
  localparam int EQCB_CFG_CM_LSB = 3;
  localparam int EQCB_CFG_DE_EN_BIT = 2;
  localparam int EQCB_CFG_LVL_MSB = 1;
  localparam int EQCB_CFG_LVL_LSB = 0;

  // Swing 10, offset 10, de-emphasis off, level 01 (register bits 7:1)
  localparam logic [6:0] EQCB_DRV_CFG_RST = 7'h51;
  localparam logic EQCB_LAUNCH_RST = 1'b0;
  localparam logic EQCB_GEN_BIT_RST = 1'b0;

  localparam logic [4:0] EQCB_ACQ_SETTLE_CYCLES = 5'h10;

  typedef enum logic [2:0] {
    EQCB_ACQ_IDLE  = 3'b001,
    EQCB_ACQ_ADAPT = 3'b010,
    EQCB_ACQ_LOCK  = 3'b100
  } eqcb_acq_state_t;

endpackage : eqcb_pkg

// >>> eqcb_register_bank.sv
// Register bank and acquisition control of the cable equalizer
`timescale 1ns/1ps
module eqcb_register_bank (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic carrier_present,
  output logic [1:0] diff_output_swing_a,
  output logic [1:0] diff_output_swing_b,
  output logic [1:0] output_common_mode_level_a,
  output logic [1:0] output_common_mode_level_b,
  output logic deemph_en_a,
  output logic deemph_en_b,
  output logic [1:0] deemph_level_a,
  output logic [1:0] deemph_level_b,
  output logic launch_atten_sel,
  output logic acq_locked
);
  import eqcb_pkg::*;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction : addr_hit

  logic acq_rst_ff;
  logic full_rst_ff;
  logic drv_sel_ff;
  logic launch_atten_ff;
  logic [6:0] drv_cfg_ff [2];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  eqcb_acq_state_t acq_state_ff;
  eqcb_acq_state_t nxt_acq_state;
  logic [4:0] acq_cnt_ff;
  logic acq_locked_ff;
  logic wr_gen;
  logic wr_drv;
  logic wr_launch;

  assign wr_gen = reg_wr_en && addr_hit(reg_addr, EQCB_GEN_CTRL_OFS);
  assign wr_drv = reg_wr_en && addr_hit(reg_addr, EQCB_DRV_OFS);
  assign wr_launch = reg_wr_en && addr_hit(reg_addr, EQCB_LAUNCH_OFS);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acq_rst_ff <= EQCB_GEN_BIT_RST;
      full_rst_ff <= EQCB_GEN_BIT_RST;
      drv_sel_ff <= EQCB_GEN_BIT_RST;
    end else if (full_rst_ff) begin
      acq_rst_ff <= EQCB_GEN_BIT_RST;
      full_rst_ff <= EQCB_GEN_BIT_RST;
      drv_sel_ff <= EQCB_GEN_BIT_RST;
    end else if (wr_gen) begin
      acq_rst_ff <= reg_wdata[EQCB_GEN_ACQ_RST_BIT];
      full_rst_ff <= reg_wdata[EQCB_GEN_FULL_RST_BIT];
      drv_sel_ff <= reg_wdata[EQCB_GEN_DRV_SEL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      launch_atten_ff <= EQCB_LAUNCH_RST;
    end else if (full_rst_ff) begin
      launch_atten_ff <= EQCB_LAUNCH_RST;
    end else if (wr_launch) begin
      launch_atten_ff <= reg_wdata[EQCB_LAUNCH_BIT];
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_drv
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          drv_cfg_ff[i] <= EQCB_DRV_CFG_RST;
        end else if (full_rst_ff) begin
          drv_cfg_ff[i] <= EQCB_DRV_CFG_RST;
        end else if (wr_drv && (drv_sel_ff == 1'(i))) begin
          drv_cfg_ff[i] <= reg_wdata[7:1];
        end
      end
    end
  endgenerate

  assign diff_output_swing_a = drv_cfg_ff[0][EQCB_CFG_SWING_MSB:EQCB_CFG_SWING_LSB];
  assign diff_output_swing_b = drv_cfg_ff[1][EQCB_CFG_SWING_MSB:EQCB_CFG_SWING_LSB];
  assign output_common_mode_level_a = drv_cfg_ff[0][EQCB_CFG_CM_MSB:EQCB_CFG_CM_LSB];
  assign output_common_mode_level_b = drv_cfg_ff[1][EQCB_CFG_CM_MSB:EQCB_CFG_CM_LSB];
  assign deemph_en_a = drv_cfg_ff[0][EQCB_CFG_DE_EN_BIT];
  assign deemph_en_b = drv_cfg_ff[1][EQCB_CFG_DE_EN_BIT];
  assign deemph_level_a = drv_cfg_ff[0][EQCB_CFG_LVL_MSB:EQCB_CFG_LVL_LSB];
  assign deemph_level_b = drv_cfg_ff[1][EQCB_CFG_LVL_MSB:EQCB_CFG_LVL_LSB];
  assign launch_atten_sel = launch_atten_ff;

  // Read mux, unmapped reads zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (addr_hit(reg_addr, EQCB_GEN_CTRL_OFS)) begin
      nxt_rdata[EQCB_GEN_ACQ_RST_BIT] = acq_rst_ff;
      nxt_rdata[EQCB_GEN_FULL_RST_BIT] = full_rst_ff;
      nxt_rdata[EQCB_GEN_DRV_SEL_BIT] = drv_sel_ff;
    end else if (addr_hit(reg_addr, EQCB_DRV_OFS)) begin
      nxt_rdata = {drv_cfg_ff[drv_sel_ff], 1'b0};
    end else if (addr_hit(reg_addr, EQCB_LAUNCH_OFS)) begin
      nxt_rdata[EQCB_LAUNCH_BIT] = launch_atten_ff;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_en;
      if (reg_rd_en) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // Acquisition machine next state
  always_comb begin
    nxt_acq_state = acq_state_ff;
    case (acq_state_ff)
      EQCB_ACQ_IDLE: begin
        if (carrier_present) begin
          nxt_acq_state = EQCB_ACQ_ADAPT;
        end
      end
      EQCB_ACQ_ADAPT: begin
        if (!carrier_present) begin
          nxt_acq_state = EQCB_ACQ_IDLE;
        end else if (acq_cnt_ff == EQCB_ACQ_SETTLE_CYCLES - 5'h01) begin
          nxt_acq_state = EQCB_ACQ_LOCK;
        end
      end
      EQCB_ACQ_LOCK: begin
        if (!carrier_present) begin
          nxt_acq_state = EQCB_ACQ_IDLE;
        end
      end
      default: begin
        nxt_acq_state = EQCB_ACQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acq_state_ff <= EQCB_ACQ_IDLE;
      acq_cnt_ff <= 5'h00;
      acq_locked_ff <= 1'b0;
    end else if (full_rst_ff || acq_rst_ff) begin
      acq_state_ff <= EQCB_ACQ_IDLE;
      acq_cnt_ff <= 5'h00;
      acq_locked_ff <= 1'b0;
    end else begin
      acq_state_ff <= nxt_acq_state;
      acq_locked_ff <= (nxt_acq_state == EQCB_ACQ_LOCK);
      if (acq_state_ff == EQCB_ACQ_ADAPT && nxt_acq_state == EQCB_ACQ_ADAPT) begin
        acq_cnt_ff <= acq_cnt_ff + 5'h01;
      end else begin
        acq_cnt_ff <= 5'h00;
      end
    end
  end

  assign acq_locked = acq_locked_ff;

  // Checks
  AST_FULL_RST_REGS: assert property (@(posedge core_clk) disable iff (!arst_n)
    full_rst_ff |=> (launch_atten_ff == EQCB_LAUNCH_RST) && (drv_cfg_ff[0] == EQCB_DRV_CFG_RST)
      && (drv_cfg_ff[1] == EQCB_DRV_CFG_RST) && !full_rst_ff && !drv_sel_ff && !acq_rst_ff)
    else $error("full reset did not restore registers");

  AST_FULL_RST_ACQ: assert property (@(posedge core_clk) disable iff (!arst_n)
    full_rst_ff |=> (acq_state_ff == EQCB_ACQ_IDLE) && !acq_locked_ff)
    else $error("full reset did not idle acquisition");

  AST_ACQ_RST_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    acq_rst_ff |=> (acq_state_ff == EQCB_ACQ_IDLE) && (acq_cnt_ff == 5'h00))
    else $error("acquisition reset did not idle machine");

  AST_ACQ_RST_KEEPS: assert property (@(posedge core_clk) disable iff (!arst_n)
    (acq_rst_ff && !full_rst_ff && !reg_wr_en) |=>
      $stable(launch_atten_ff) && $stable(drv_cfg_ff[0]) && $stable(drv_cfg_ff[1]))
    else $error("acquisition reset disturbed registers");

  AST_SWING_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_drv && !full_rst_ff && !drv_sel_ff) |=> diff_output_swing_a == $past(reg_wdata[7:6]))
    else $error("swing field not written");

  AST_CM_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_drv && !full_rst_ff && drv_sel_ff) |=>
      output_common_mode_level_b == $past(reg_wdata[5:4]))
    else $error("offset field not written");

  AST_DEEMPH_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_drv && !full_rst_ff && !drv_sel_ff) |=>
      (deemph_en_a == $past(reg_wdata[3])) && (deemph_level_a == $past(reg_wdata[2:1])))
    else $error("de-emphasis fields not written");

  AST_LAUNCH_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_launch && !full_rst_ff) |=> launch_atten_sel == $past(reg_wdata[7]))
    else $error("launch bit not written");

  AST_DRV_ISOLATE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_drv && !full_rst_ff && !drv_sel_ff) |=> $stable(drv_cfg_ff[1]))
    else $error("unselected driver copy changed");

  AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n)
    (reg_rd_en && addr_hit(reg_addr, EQCB_DRV_OFS)) |=> reg_rvalid && (reg_rdata[0] == 1'b0))
    else $error("reserved bit read nonzero");

  COV_FULL_RST: cover property (@(posedge core_clk) disable iff (!arst_n)
    wr_gen && reg_wdata[EQCB_GEN_FULL_RST_BIT] ##1 full_rst_ff);
  COV_LOCK: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(acq_locked_ff));
  COV_DRV_B: cover property (@(posedge core_clk) disable iff (!arst_n) wr_drv && drv_sel_ff);

endmodule : eqcb_register_bank

// >>> eqcb_host.sv
// Host model driving the parallel configuration port
`timescale 1ns/1ps
module eqcb_host (
  input wire logic core_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    v = reg_rvalid;
    d = reg_rdata;
    reg_rd_en = 1'b0;
  endtask : rd
endmodule : eqcb_host

// >>> eqcb_register_bank_tb.sv
// Self-checking testbench for the equalizer register bank
`timescale 1ns/1ps
module eqcb_register_bank_tb;
  import eqcb_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic carrier_present = 1'b0;
  logic reg_wr_en, reg_rd_en, reg_rvalid, rd_v, de_a, de_b, launch, locked;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_d;
  logic [1:0] sw_a, sw_b, cm_a, cm_b, lv_a, lv_b;
  int miscompares = 0;
  int total_checks = 0;
  wire [7:0] out_a = {sw_a, cm_a, de_a, lv_a, 1'b0};
  wire [7:0] out_b = {sw_b, cm_b, de_b, lv_b, 1'b0};
  always #2 core_clk = ~core_clk;
  eqcb_host i_eqcb_host (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  eqcb_register_bank i_eqcb_register_bank (.core_clk(core_clk), .arst_n(arst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .carrier_present(carrier_present),
    .diff_output_swing_a(sw_a), .diff_output_swing_b(sw_b),
    .output_common_mode_level_a(cm_a), .output_common_mode_level_b(cm_b),
    .deemph_en_a(de_a), .deemph_en_b(de_b), .deemph_level_a(lv_a), .deemph_level_b(lv_b),
    .launch_atten_sel(launch), .acq_locked(locked));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_eqcb_host.rd(a, rd_d, rd_v);
    chk({7'h00, rd_v}, 8'h01);
    chk(rd_d, exp);
  endtask : rchk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic t_reset();
    chk(out_a, 8'hA2);
    chk(out_b, 8'hA2);
    chk({7'h00, launch}, 8'h00);
    rchk(EQCB_DRV_OFS, 8'hA2);
    rchk(EQCB_LAUNCH_OFS, 8'h00);
    rchk(8'h10, 8'h00);
  endtask : t_reset
  task automatic t_drivers();
    logic [1:0] c;
    i_eqcb_host.wr(EQCB_DRV_OFS, 8'hFF);
    chk(out_a, 8'hFE);
    chk(out_b, 8'hA2);
    rchk(EQCB_DRV_OFS, 8'hFE);
    i_eqcb_host.wr(EQCB_GEN_CTRL_OFS, 8'h04);
    rchk(EQCB_GEN_CTRL_OFS, 8'h04);
    rchk(EQCB_DRV_OFS, 8'hA2);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      i_eqcb_host.wr(EQCB_DRV_OFS, {4{c}});
      chk(out_b, {4{c}} & 8'hFE);
      chk(out_a, 8'hFE);
    end
  endtask : t_drivers
  task automatic t_launch();
    i_eqcb_host.wr(EQCB_LAUNCH_OFS, 8'hFF);
    chk({7'h00, launch}, 8'h01);
    rchk(EQCB_LAUNCH_OFS, 8'h80);
    i_eqcb_host.wr(EQCB_LAUNCH_OFS, 8'h7F);
    chk({7'h00, launch}, 8'h00);
  endtask : t_launch
  task automatic t_acq();
    @(negedge core_clk);
    carrier_present = 1'b1;
    repeat (10) @(negedge core_clk);
    chk({7'h00, locked}, 8'h00);
    repeat (10) @(negedge core_clk);
    chk({7'h00, locked}, 8'h01);
    i_eqcb_host.wr(EQCB_GEN_CTRL_OFS, 8'h05);
    repeat (20) @(negedge core_clk);
    chk({7'h00, locked}, 8'h00);
    chk(out_b, 8'hFE);
    i_eqcb_host.wr(EQCB_GEN_CTRL_OFS, 8'h04);
    repeat (20) @(negedge core_clk);
    chk({7'h00, locked}, 8'h01);
  endtask : t_acq
  task automatic t_full();
    i_eqcb_host.wr(EQCB_LAUNCH_OFS, 8'h80);
    i_eqcb_host.wr(EQCB_GEN_CTRL_OFS, 8'h06);
    @(negedge core_clk);
    chk(out_a, 8'hA2);
    chk(out_b, 8'hA2);
    chk({6'h00, launch, locked}, 8'h00);
    rchk(EQCB_GEN_CTRL_OFS, 8'h00);
    rchk(EQCB_DRV_OFS, 8'hA2);
  endtask : t_full
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    arst_n = 1'b1;
    t_reset();
    t_drivers();
    t_launch();
    t_acq();
    t_full();
    report_and_stop();
  end
endmodule : eqcb_register_bank_tb
